// ### core/opld_pkg.sv
// package: constants, types and helpers for the output phase-loss detector
package opld_pkg;

    // clock and control cycle
    localparam int CLK_PERIOD_NS  = 40;
    localparam int CTL_CYCLE_NS   = 40000;
    localparam int CTL_CYCLE_CLKS = (CTL_CYCLE_NS / CLK_PERIOD_NS) < 1 ? 1 : (CTL_CYCLE_NS / CLK_PERIOD_NS);

    // data widths
    localparam int SPD_W = 16;
    localparam int CUR_W = 16;

    // speed thresholds (r/min, mm/s, r/min)
    localparam logic [15:0] THR_ROTARY = 16'h0032;
    localparam logic [15:0] THR_LINEAR = 16'h0032;
    localparam logic [15:0] THR_DD     = 16'h0019;

    // register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CLEAR  = 8'h08;
    localparam logic [7:0] OFS_LEVEL  = 8'h0c;

    // control fields
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int CTRL_ML_BIT  = 2;
    localparam int CTRL_MT_LSB  = 4;
    localparam int CTRL_PER_LSB = 8;

    // status fields
    localparam int STAT_ALARM_BIT = 0;
    localparam int STAT_EVAL_BIT  = 1;
    localparam int STAT_MASK_LSB  = 4;
    localparam int STAT_SUB_LSB   = 8;
    localparam int STAT_CNT_LSB   = 16;

    // clear field
    localparam int CLR_ALARM_BIT = 0;

    // reset values
    localparam logic        EN_RST    = 1'b0;
    localparam logic        SRC_RST   = 1'b0;
    localparam logic        ML_RST    = 1'b0;
    localparam logic [1:0]  MT_RST    = 2'h0;
    localparam logic [7:0]  PER_RST   = 8'h08;
    localparam logic [15:0] LEVEL_RST = 16'h0040;

    // alarm sub-code for output phase loss
    localparam logic [3:0] SUBCODE_OUT_LOSS = 4'h2;

    typedef enum logic [1:0] {
        MT_ROTARY = 2'b00,
        MT_LINEAR = 2'b01,
        MT_DD     = 2'b10
    } opld_motor_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WATCH = 2'b01,
        ST_ALARM = 2'b10
    } opld_state_type;

    // magnitude of a signed value
    function automatic logic [15:0] opld_abs(input logic signed [15:0] v);
        opld_abs = v[15] ? 16'(-v) : 16'(v);
    endfunction

    // speed threshold per motor type
    function automatic logic [15:0] opld_threshold(input logic [1:0] mt);
        case (mt)
            MT_LINEAR: opld_threshold = THR_LINEAR;
            MT_DD:     opld_threshold = THR_DD;
            default:   opld_threshold = THR_ROTARY;
        endcase
    endfunction

endpackage

// ### core/opld_tick.sv
// control cycle enable divider
`timescale 1ns/1ps
`default_nettype none
module opld_tick
    import opld_pkg::*;
#(
    parameter int DIV = CTL_CYCLE_CLKS
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // enable pulse
    output logic      tick
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_tick;

    always_comb begin
        next_tick = (cnt == LAST);
        next_cnt  = next_tick ? '0 : cnt + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end

endmodule
`default_nettype wire

// ### core/opld_phase_judge.sv
// per-phase open judgement from output current magnitude
`timescale 1ns/1ps
`default_nettype none
module opld_phase_judge
    import opld_pkg::*;
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // phase currents
    input  wire logic [CUR_W-1:0] current_u,
    input  wire logic [CUR_W-1:0] current_v,
    input  wire logic [CUR_W-1:0] current_w,
    input  wire logic [15:0]      open_level,
    // judgement
    output logic [2:0]            open_mask,
    output logic                  single_open
);

    logic [CUR_W-1:0] cur [3];
    logic [2:0]       next_mask;
    logic             next_single;

    assign cur[0] = current_u;
    assign cur[1] = current_v;
    assign cur[2] = current_w;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ph
            assign next_mask[g] = opld_abs(cur[g]) < open_level;
        end
    endgenerate

    // exactly one phase open, two or three not flagged
    always_comb begin
        next_single = (^next_mask) & ~(&next_mask); // [RQ6]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_mask   <= 3'h0;
            single_open <= 1'b0;
        end else begin
            open_mask   <= next_mask;
            single_open <= next_single;
        end
    end

endmodule
`default_nettype wire

// ### core/opld_top.sv
// output phase-loss detector with apb register file
`timescale 1ns/1ps
`default_nettype none
//Behaviour
// [RQ1] any other alarm or warning active suspends phase-loss detection
// [RQ2] motor-less operation selected means phase loss is never reported
// [RQ3] measured-speed source: evaluate only servo-on and speed at or above threshold
// [RQ4] command source: evaluate only servo-on and command at or above threshold
// [RQ5] no evaluation while brake interlock output is on
// [RQ6] detect only exactly one open phase of three
// [RQ7] enable setting, 0 disables and is reset default, 1 enables
// [RQ8] judgment source setting, 0 measured speed default, 1 speed command
// [RQ9] torque control with command source never raises the phase-loss sub-code
// [RQ10] detected open output phase raises the open-phase error alarm
// [RQ11] speed magnitude compared each control cycle, all gates in same cycle
module opld_top
    import opld_pkg::*;
#(
    parameter int TICK_DIV = CTL_CYCLE_CLKS
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // amplifier state
    input  wire logic             servo_on,
    input  wire logic             torque_mode,
    input  wire logic             other_alarm,
    input  wire logic             brake_interlock_out,
    input  wire logic [SPD_W-1:0] motor_speed,
    input  wire logic [SPD_W-1:0] speed_cmd,
    // output phase currents
    input  wire logic [CUR_W-1:0] current_u,
    input  wire logic [CUR_W-1:0] current_v,
    input  wire logic [CUR_W-1:0] current_w,
    // alarm
    output logic                  open_phase_error_alarm,
    output logic [3:0]            output_phase_loss_subcode,
    output logic                  eval_active
);

    // settings
    logic        phase_loss_enable;
    logic        judgment_source_select;
    logic        motorless_op_select;
    logic [1:0]  motor_kind;
    logic [7:0]  persist_cnt;
    logic [15:0] open_level;
    logic        next_phase_loss_enable;
    logic        next_judgment_source_select;
    logic        next_motorless_op_select;
    logic [1:0]  next_motor_kind;
    logic [7:0]  next_persist_cnt;
    logic [15:0] next_open_level;
    logic [31:0] next_prdata;

    // detector state
    opld_state_type state;
    opld_state_type next_state;
    logic [7:0]     run_cnt;
    logic [7:0]     next_run_cnt;
    logic           alarm;
    logic           next_alarm;
    logic [3:0]     subcode;
    logic [3:0]     next_subcode;
    logic           eval_q;
    logic           next_eval_q;

    // combinational helpers
    logic           tick;
    logic [2:0]     open_mask;
    logic           single_open;
    logic           wr_acc;
    logic           rd_setup;
    logic           clear_req;
    logic           addr_ok;
    logic [15:0]    sel_mag;
    logic           speed_ok;
    logic           gate;
    logic           fire;
    logic [7:0]     persist_lim;

    opld_tick #(
        .DIV (TICK_DIV)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    opld_phase_judge u_judge (
        .pclk        (pclk),
        .presetn     (presetn),
        .current_u   (current_u),
        .current_v   (current_v),
        .current_w   (current_w),
        .open_level  (open_level),
        .open_mask   (open_mask),
        .single_open (single_open)
    );

    // apb decode
    always_comb begin
        addr_ok  = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
                   (paddr == OFS_CLEAR) || (paddr == OFS_LEVEL);
        wr_acc   = psel & penable & pwrite;
        rd_setup = psel & ~penable & ~pwrite;
        pready   = 1'b1;
        pslverr  = psel & penable & ~addr_ok;
    end

    // register writes and read data
    always_comb begin
        next_phase_loss_enable      = phase_loss_enable;
        next_judgment_source_select = judgment_source_select;
        next_motorless_op_select    = motorless_op_select;
        next_motor_kind             = motor_kind;
        next_persist_cnt            = persist_cnt;
        next_open_level             = open_level;
        clear_req                   = 1'b0;
        next_prdata                 = prdata;
        if (wr_acc) begin
            case (paddr)
                OFS_CTRL: begin
                    next_phase_loss_enable      = pwdata[CTRL_EN_BIT]; // [RQ7]
                    next_judgment_source_select = pwdata[CTRL_SRC_BIT]; // [RQ8]
                    next_motorless_op_select    = pwdata[CTRL_ML_BIT];
                    next_motor_kind             = pwdata[CTRL_MT_LSB +: 2];
                    next_persist_cnt            = pwdata[CTRL_PER_LSB +: 8];
                end
                OFS_CLEAR: begin
                    clear_req = pwdata[CLR_ALARM_BIT];
                end
                OFS_LEVEL: begin
                    next_open_level = pwdata[15:0];
                end
                default: begin
                    next_open_level = open_level;
                end
            endcase
        end
        if (rd_setup) begin
            next_prdata = 32'h0000_0000;
            case (paddr)
                OFS_CTRL: begin
                    next_prdata[CTRL_EN_BIT]       = phase_loss_enable;
                    next_prdata[CTRL_SRC_BIT]      = judgment_source_select;
                    next_prdata[CTRL_ML_BIT]       = motorless_op_select;
                    next_prdata[CTRL_MT_LSB +: 2]  = motor_kind;
                    next_prdata[CTRL_PER_LSB +: 8] = persist_cnt;
                end
                OFS_STATUS: begin
                    next_prdata[STAT_ALARM_BIT]    = alarm;
                    next_prdata[STAT_EVAL_BIT]     = eval_q;
                    next_prdata[STAT_MASK_LSB +: 3] = open_mask;
                    next_prdata[STAT_SUB_LSB +: 4]  = subcode;
                    next_prdata[STAT_CNT_LSB +: 8]  = run_cnt;
                end
                OFS_LEVEL: begin
                    next_prdata[15:0] = open_level;
                end
                default: begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_loss_enable      <= EN_RST; // [RQ7]
            judgment_source_select <= SRC_RST; // [RQ8]
            motorless_op_select    <= ML_RST;
            motor_kind             <= MT_RST;
            persist_cnt            <= PER_RST;
            open_level             <= LEVEL_RST;
            prdata                 <= 32'h0000_0000;
        end else begin
            phase_loss_enable      <= next_phase_loss_enable;
            judgment_source_select <= next_judgment_source_select;
            motorless_op_select    <= next_motorless_op_select;
            motor_kind             <= next_motor_kind;
            persist_cnt            <= next_persist_cnt;
            open_level             <= next_open_level;
            prdata                 <= next_prdata;
        end
    end

    // evaluation gate, all terms in one cycle
    always_comb begin
        sel_mag  = judgment_source_select ? opld_abs(speed_cmd) : opld_abs(motor_speed); // [RQ11]
        speed_ok = sel_mag >= opld_threshold(motor_kind); // [RQ3] [RQ4]
        gate     = phase_loss_enable
                 & ~motorless_op_select // [RQ2]
                 & ~other_alarm // [RQ1]
                 & ~brake_interlock_out // [RQ5]
                 & ~(torque_mode & judgment_source_select) // [RQ9]
                 & servo_on // [RQ3] [RQ4]
                 & speed_ok; // [RQ11]
        persist_lim = (persist_cnt == 8'h00) ? 8'h01 : persist_cnt;
        fire        = tick & gate & single_open & (run_cnt + 8'h01 >= persist_lim); // [RQ6]
    end

    // detector sequence
    always_comb begin
        next_state   = state;
        next_run_cnt = run_cnt;
        next_alarm   = alarm;
        next_subcode = subcode;
        next_eval_q  = eval_q;
        if (tick) begin
            next_eval_q = gate;
        end
        case (state)
            ST_IDLE: begin
                next_run_cnt = 8'h00;
                if (fire) begin
                    next_state   = ST_ALARM;
                    next_alarm   = 1'b1; // [RQ10]
                    next_subcode = SUBCODE_OUT_LOSS;
                end else if (tick & gate & single_open) begin
                    next_state   = ST_WATCH;
                    next_run_cnt = 8'h01;
                end
            end
            ST_WATCH: begin
                if (fire) begin
                    next_state   = ST_ALARM;
                    next_alarm   = 1'b1; // [RQ10]
                    next_subcode = SUBCODE_OUT_LOSS;
                    next_run_cnt = 8'h00;
                end else if (tick & ~(gate & single_open)) begin
                    next_state   = ST_IDLE; // [RQ11]
                    next_run_cnt = 8'h00;
                end else if (tick) begin
                    next_run_cnt = run_cnt + 8'h01;
                end
            end
            ST_ALARM: begin
                next_run_cnt = 8'h00;
                if (clear_req) begin
                    next_state   = ST_IDLE;
                    next_alarm   = 1'b0;
                    next_subcode = 4'h0;
                end
            end
            default: begin
                next_state   = ST_IDLE;
                next_run_cnt = 8'h00;
                next_alarm   = 1'b0;
                next_subcode = 4'h0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= ST_IDLE;
            run_cnt <= 8'h00;
            alarm   <= 1'b0;
            subcode <= 4'h0;
            eval_q  <= 1'b0;
        end else begin
            state   <= next_state;
            run_cnt <= next_run_cnt;
            alarm   <= next_alarm;
            subcode <= next_subcode;
            eval_q  <= next_eval_q;
        end
    end

    // outputs
    assign open_phase_error_alarm    = alarm;
    assign output_phase_loss_subcode = subcode;
    assign eval_active               = eval_q;

endmodule
`default_nettype wire

// ### tb/opld_motor_model.sv
// motor output wiring model: phase currents with open phases
`timescale 1ns/1ps
`default_nettype none
module opld_motor_model
    import opld_pkg::*;
(
    // clock
    input  wire logic             pclk,
    // open phases (u, v, w)
    input  wire logic [2:0]       open_mask,
    // phase currents
    output logic [CUR_W-1:0]      current_u,
    output logic [CUR_W-1:0]      current_v,
    output logic [CUR_W-1:0]      current_w
);
    logic             sgn = 1'b0;
    logic [CUR_W-1:0] amp;
    // sign flips every cycle, so a stuck sample never looks healthy
    always @(posedge pclk) begin
        sgn <= ~sgn;
    end
    assign amp = sgn ? 16'hfc00 : 16'h0400;
    // an open phase carries no current, any number of phases may be open
    assign current_u = open_mask[0] ? 16'h0000 : amp;
    assign current_v = open_mask[1] ? 16'h0000 : amp;
    assign current_w = open_mask[2] ? 16'h0000 : amp;
endmodule
`default_nettype wire

// ### tb/opld_properties.sv
// concurrent checks on the detector ports
`timescale 1ns/1ps
`default_nettype none
module opld_properties
    import opld_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // apb
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic       pready,
    input  wire logic       pslverr,
    // amplifier state
    input  wire logic       servo_on,
    input  wire logic       other_alarm,
    input  wire logic       brake_interlock_out,
    // alarm
    input  wire logic       open_phase_error_alarm,
    input  wire logic [3:0] output_phase_loss_subcode,
    input  wire logic       eval_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence clear_write;
        psel && penable && pwrite && paddr == OFS_CLEAR && pwdata[0];
    endsequence
    sequence gate_rise;
        $rose(eval_active);
    endsequence
    chk_eval_servo_on: assert property (gate_rise |-> $past(servo_on))
        else $error("evaluation started in servo-off");
    chk_other_alarm_gate: assert property (gate_rise |-> !$past(other_alarm))
        else $error("evaluation started during another alarm");
    chk_brake_gate: assert property (gate_rise |-> !$past(brake_interlock_out))
        else $error("evaluation started with brake interlock on");
    chk_alarm_needs_eval: assert property ($rose(open_phase_error_alarm) |-> eval_active)
        else $error("alarm rose without evaluation");
    chk_subcode_pairs: assert property (output_phase_loss_subcode ==
        (open_phase_error_alarm ? SUBCODE_OUT_LOSS : 4'h0))
        else $error("sub-code does not match alarm");
    chk_alarm_sticky: assert property (open_phase_error_alarm && !psel [*2] |=> open_phase_error_alarm)
        else $error("alarm dropped without clear");
    chk_clear_drops: assert property (open_phase_error_alarm ##0 clear_write |=> !open_phase_error_alarm)
        else $error("clear did not drop alarm");
    chk_apb_answer: assert property (psel && penable |-> pready && pslverr == (paddr > OFS_LEVEL || paddr[1:0] != 2'h0))
        else $error("apb answer wrong");
endmodule
`default_nettype wire

// ### tb/opld_test.sv
// self-checking bench for the output phase-loss detector
`timescale 1ns/1ps
`default_nettype none
module opld_test;
    import opld_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, alarm, eval_active;
    logic servo_on = 1'b0, torque_mode = 1'b0, other_alarm = 1'b0, brake_interlock_out = 1'b0;
    logic [15:0] motor_speed = 16'h0, speed_cmd = 16'h0, cu, cv, cw;
    logic [3:0] subcode;
    logic [2:0] open_mask = 3'h0;
    int err_count = 0, checks = 0;
    always #20 pclk = ~pclk;
    opld_motor_model opld_motor_model_inst (.pclk(pclk), .open_mask(open_mask), .current_u(cu),
        .current_v(cv), .current_w(cw));
    opld_top #(.TICK_DIV(4)) opld_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servo_on(servo_on), .torque_mode(torque_mode), .other_alarm(other_alarm),
        .brake_interlock_out(brake_interlock_out), .motor_speed(motor_speed), .speed_cmd(speed_cmd),
        .current_u(cu), .current_v(cv), .current_w(cw), .open_phase_error_alarm(alarm),
        .output_phase_loss_subcode(subcode), .eval_active(eval_active));
    task print_verdict;
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        logic done;
        done = 1'b0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && !done; n++) begin
            @(posedge pclk);
            done = (pready === 1'b1);
        end
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (!done) begin
            err_count++;
            print_verdict;
        end
    endtask
    // one detection attempt under the given settings and amplifier state
    task run_case(input logic [31:0] c, input logic so, tq, oa, br, input logic [15:0] ms, cs,
                  input logic [2:0] m, input logic e);
        int n;
        @(posedge pclk);
        servo_on <= so; torque_mode <= tq; other_alarm <= oa; brake_interlock_out <= br;
        motor_speed <= ms; speed_cmd <= cs;
        apb(1'b1, OFS_CTRL, c, q);
        @(posedge pclk);
        open_mask <= m;
        for (n = 0; n < 60 && alarm !== 1'b1; n++) @(posedge pclk);
        check("alarm", {31'h0, alarm}, {31'h0, e});
        if (e && alarm !== 1'b1) print_verdict;
        apb(1'b0, OFS_STATUS, 32'h0, q);
        check("status", q & 32'h0000_0f71, (e ? 32'h0000_0201 : 32'h0) | {25'h0, m, 4'h0});
        @(posedge pclk);
        open_mask <= 3'h0;
        servo_on <= 1'b0;
        repeat (10) @(posedge pclk);
        check("held", {31'h0, alarm}, {31'h0, e});
        apb(1'b1, OFS_CLEAR, 32'h1, q);
        repeat (2) @(posedge pclk);
        check("cleared", {31'h0, alarm}, 32'h0);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, 8'h10, 32'hffff_ffff, q);
        check("unmapped write", {31'h0, last_err}, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0, q);
        check("ctrl reset", q, 32'h0000_0800);
        apb(1'b0, OFS_LEVEL, 32'h0, q);
        check("level reset", q, 32'h0000_0040);
        apb(1'b1, OFS_LEVEL, 32'h0000_0123, q);
        apb(1'b0, OFS_LEVEL, 32'h0, q);
        check("level write", q, 32'h0000_0123);
        apb(1'b0, 8'h10, 32'h0, q);
        check("unmapped", {q[31:1], last_err}, 32'h1);
        apb(1'b0, OFS_CLEAR, 32'h0, q);
        check("clear read", q, 32'h0);
        run_case(32'h0200, 1, 0, 0, 0, 16'd100, 16'd100, 3'b001, 0);
        run_case(32'h0201, 1, 0, 0, 0, 16'd100, 16'd100, 3'b001, 1);
        run_case(32'h0201, 1, 0, 0, 0, 16'd100, 16'd100, 3'b011, 0);
        run_case(32'h0201, 1, 0, 0, 0, 16'd100, 16'd100, 3'b111, 0);
        run_case(32'h0205, 1, 0, 0, 0, 16'd100, 16'd100, 3'b100, 0);
        run_case(32'h0201, 1, 0, 1, 0, 16'd100, 16'd100, 3'b010, 0);
        run_case(32'h0201, 1, 0, 0, 1, 16'd100, 16'd100, 3'b010, 0);
        run_case(32'h0201, 0, 0, 0, 0, 16'd100, 16'd100, 3'b001, 0);
        run_case(32'h0201, 1, 0, 0, 0, 16'd49, 16'd100, 3'b001, 0);
        run_case(32'h0201, 1, 0, 0, 0, 16'd50, 16'd0, 3'b001, 1);
        run_case(32'h0201, 1, 0, 0, 0, 16'hffce, 16'd0, 3'b001, 1);
        run_case(32'h0201, 1, 0, 0, 0, 16'hffcf, 16'd100, 3'b001, 0);
        run_case(32'h0211, 1, 0, 0, 0, 16'd49, 16'd100, 3'b001, 0);
        run_case(32'h0211, 1, 0, 0, 0, 16'd50, 16'd0, 3'b001, 1);
        run_case(32'h0221, 1, 0, 0, 0, 16'd24, 16'd100, 3'b001, 0);
        run_case(32'h0221, 1, 0, 0, 0, 16'd25, 16'd0, 3'b001, 1);
        run_case(32'h0203, 1, 0, 0, 0, 16'd0, 16'd50, 3'b001, 1);
        run_case(32'h0203, 1, 0, 0, 0, 16'd100, 16'd49, 3'b001, 0);
        run_case(32'h0203, 0, 0, 0, 0, 16'd100, 16'd100, 3'b001, 0);
        run_case(32'h0203, 1, 1, 0, 0, 16'd100, 16'd100, 3'b001, 0);
        run_case(32'h0201, 1, 1, 0, 0, 16'd100, 16'd0, 3'b001, 1);
        // alarm raised, then a reset in mid-run returns every setting to default
        @(posedge pclk);
        servo_on <= 1'b1;
        open_mask <= 3'b001;
        for (int n = 0; n < 60 && alarm !== 1'b1; n++) @(posedge pclk);
        check("pre-reset alarm", {31'h0, alarm}, 32'h1);
        if (alarm !== 1'b1) print_verdict;
        presetn <= 1'b0;
        servo_on <= 1'b0;
        open_mask <= 3'h0;
        repeat (2) @(posedge pclk);
        check("reset alarm", {31'h0, alarm}, 32'h0);
        check("reset subcode", {28'h0, subcode}, 32'h0);
        check("reset eval", {31'h0, eval_active}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0, q);
        check("ctrl after reset", q, 32'h0000_0800);
        apb(1'b0, OFS_LEVEL, 32'h0, q);
        check("level after reset", q, 32'h0000_0040);
        print_verdict;
    end
endmodule
bind opld_top opld_properties opld_properties_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .servo_on(servo_on), .other_alarm(other_alarm), .brake_interlock_out(brake_interlock_out),
    .open_phase_error_alarm(open_phase_error_alarm), .output_phase_loss_subcode(output_phase_loss_subcode),
    .eval_active(eval_active));
`default_nettype wire
